// >>> design/tnl_consts.vh
// Constants for the triggered nibble link transmitter
`ifndef TNL_CONSTS_VH
`define TNL_CONSTS_VH

// Clock and unit time
`define TNL_CLK_NS 4
`define TNL_UT_MIN_NS 1500
`define TNL_UT_STEP_NS 500
`define TNL_UT_MIN_CYC (`TNL_UT_MIN_NS / `TNL_CLK_NS)
`define TNL_UT_STEP_CYC (`TNL_UT_STEP_NS / `TNL_CLK_NS)

// Frame timing in unit times
`define TNL_SYNC_UT 7'h38
`define TNL_NIB_BASE_UT 7'h0C
`define TNL_END_UT 7'h0C
`define TNL_TRIG_CONST_UT 7'h5A
`define TNL_TRIG_VAR_UT 7'h0C
`define TNL_LOW_SHORT_UT 7'h03
`define TNL_LOW_LONG_UT 7'h05

// Address windows of the master low time, in half unit times
`define TNL_A0_MIN_H 8'h12
`define TNL_A0_MAX_H 8'h18
`define TNL_A1_MIN_H 8'h26
`define TNL_A1_MAX_H 8'h2E
`define TNL_A2_MIN_H 8'h47
`define TNL_A2_MAX_H 8'h51
`define TNL_A3_MIN_H 8'h7B
`define TNL_A3_MAX_H 8'h87

// Checksum
`define TNL_CRC_SEED 4'h5
`define TNL_CRC_POLY 4'hD

// Register byte offsets
`define TNL_OFS_CTRL 6'h00
`define TNL_OFS_STATUS 6'h04
`define TNL_OFS_ANGLE 6'h08
`define TNL_OFS_FAULT 6'h0C
`define TNL_OFS_TEMP 6'h10
`define TNL_OFS_BASE 6'h14
`define TNL_OFS_IDW1 6'h18
`define TNL_OFS_IDW2 6'h1C

// Control fields
`define TNL_F_UT_LSB 0
`define TNL_F_LOWSEL 2
`define TNL_F_TRIGVAR 3
`define TNL_F_CTR_LSB 4
`define TNL_F_SLOW 6
`define TNL_F_ADDR_LSB 8

// Counter modes
`define TNL_CTR_NIBBLE 2'h0
`define TNL_CTR_OFF 2'h1
`define TNL_CTR_IN_CRC 2'h2

// Reset values
`define TNL_CTRL_RST 10'h000
`define TNL_FAULT_RST 2'h0

`endif

// >>> design/tnl_link_tx.v
// Triggered single-wire nibble link transmitter with register slave
`timescale 1ns/100ps
`include "tnl_consts.vh"

module tnl_link_tx (
    input wire mclk,
    input wire reset,
    input wire [5:0] avsAddress,
    input wire avsRead,
    input wire avsWrite,
    input wire [31:0] avsWriteData,
    input wire [3:0] avsByteEnable,
    output wire [31:0] avsReadData,
    output wire avsWaitrequest,
    input wire lineIn,
    output wire lineOut,
    output wire lineOe,
    output wire frameDone
);
    localparam ST_IDLE = 2'h0;
    localparam ST_LOW = 2'h1;
    localparam ST_WAIT = 2'h2;
    localparam ST_SEND = 2'h3;
    localparam IDX_SYNC = 3'h0;
    localparam IDX_DATA3 = 3'h4;
    localparam IDX_CRC = 3'h6;
    localparam IDX_END = 3'h7;

    // Register file
    reg [9:0] ctrl_ff;
    reg [11:0] angle_ff;
    reg [1:0] fault_ff;
    reg [7:0] temp_ff;
    reg [15:0] base_ff;
    reg [15:0] idw1_ff;
    reg [15:0] idw2_ff;
    reg ack_ff;
    reg [31:0] rdData_ff;

    // Link state
    reg [1:0] state_ff;
    reg [6:0] utCnt_ff;
    reg [15:0] lowCnt_ff;
    reg [2:0] nibIdx_ff;
    reg [6:0] target_ff;
    reg lineOe_ff;
    reg frameDone_ff;
    reg [3:0] statusLat_ff;
    reg [11:0] angleLat_ff;
    reg [3:0] crcLat_ff;
    reg [3:0] frameCnt_ff;
    reg rstInd_ff;
    reg [3:0] bitPos_ff;
    reg [3:0] msgId_ff;
    reg [15:0] msgWord_ff;

    reg [1:0] nxt_state;
    reg [6:0] nxt_utCnt;
    reg [15:0] nxt_lowCnt;
    reg [2:0] nxt_nibIdx;
    reg [6:0] nxt_target;
    reg nxt_lineOe;
    reg restart;
    reg startFrame;
    reg endFrame;
    reg [3:0] nibVal;
    reg [6:0] nibLen;
    reg [3:0] crcRun;
    reg [3:0] frameCrc;
    reg [7:0] msgData;
    reg [3:0] msgCrc;
    reg [31:0] rdMux;
    wire [31:0] wrWord;

    wire utTick;
    wire [1:0] utSel = ctrl_ff[`TNL_F_UT_LSB+1:`TNL_F_UT_LSB];
    wire lowLong = ctrl_ff[`TNL_F_LOWSEL];
    wire trigVar = ctrl_ff[`TNL_F_TRIGVAR];
    wire [1:0] ctrMode = ctrl_ff[`TNL_F_CTR_LSB+1:`TNL_F_CTR_LSB];
    wire slowEn = ctrl_ff[`TNL_F_SLOW];
    wire [1:0] busAddr = ctrl_ff[`TNL_F_ADDR_LSB+1:`TNL_F_ADDR_LSB];
    wire [31:0] utFull;
    wire [9:0] utCyc;
    wire [6:0] lowUt;
    wire trigHit;
    wire [15:0] msgNew;
    wire msgBit;
    wire [3:0] statusNow;
    wire wrEn;

    // Checksum table step: multiply remainder by x^4 modulo the polynomial
    function [3:0] crcTab(input [3:0] c);
        integer i;
        reg [3:0] r;
        begin
            r = c;
            for (i = 0; i < 4; i = i + 1) begin
                r = {r[2:0], 1'b0} ^ (r[3] ? `TNL_CRC_POLY : 4'h0);
            end
            crcTab = r;
        end
    endfunction

    function [3:0] crcStep(input [3:0] c, input [3:0] n);
        begin
            crcStep = n ^ crcTab(c);
        end
    endfunction

    function [31:0] wrMerge(input [31:0] old, input [31:0] d,
                            input [3:0] be);
        integer i;
        begin
            wrMerge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (be[i]) begin
                    wrMerge[i*8 +: 8] = d[i*8 +: 8];
                end
            end
        end
    endfunction

    // Low time window test, compared in half unit times against cycles
    function hitWindow(input [1:0] a, input [15:0] lowC, input [9:0] ut);
        reg [7:0] minH;
        reg [7:0] maxH;
        reg [17:0] twice;
        reg [17:0] lo;
        reg [17:0] hi;
        begin
            case (a)
                2'h0: begin
                    minH = `TNL_A0_MIN_H;
                    maxH = `TNL_A0_MAX_H;
                end
                2'h1: begin
                    minH = `TNL_A1_MIN_H;
                    maxH = `TNL_A1_MAX_H;
                end
                2'h2: begin
                    minH = `TNL_A2_MIN_H;
                    maxH = `TNL_A2_MAX_H;
                end
                default: begin
                    minH = `TNL_A3_MIN_H;
                    maxH = `TNL_A3_MAX_H;
                end
            endcase
            twice = {1'b0, lowC, 1'b0};
            lo = {10'h000, minH} * {8'h00, ut};
            hi = {10'h000, maxH} * {8'h00, ut};
            hitWindow = (twice >= lo) && (twice <= hi);
        end
    endfunction

    tnl_ut_timer utTimer (
        .mclk(mclk),
        .reset(reset),
        .restart(restart),
        .utSel(utSel),
        .utTick(utTick)
    );

    assign utFull = `TNL_UT_MIN_CYC + `TNL_UT_STEP_CYC * {30'h0, utSel};
    assign utCyc = utFull[9:0];
    assign lowUt = lowLong ? `TNL_LOW_LONG_UT : `TNL_LOW_SHORT_UT;
    assign trigHit = hitWindow(busAddr, lowCnt_ff, utCyc);
    assign msgNew = {msgId_ff, msgData, msgCrc};
    assign msgBit = (bitPos_ff == 4'h0) ? msgNew[15]
                  : msgWord_ff[4'hF - bitPos_ff];
    assign statusNow = {fault_ff[1] | rstInd_ff, fault_ff[0],
                        slowEn ? {bitPos_ff == 4'h0, msgBit}
                               : busAddr};
    assign lineOut = 1'b0;
    assign lineOe = lineOe_ff;
    assign frameDone = frameDone_ff;

    // Slow channel message content
    always @* begin
        case (msgId_ff[2:0])
            3'h1: msgData = base_ff[15:8];
            3'h2: msgData = base_ff[7:0];
            3'h4: msgData = idw1_ff[15:8];
            3'h5: msgData = idw1_ff[7:0];
            3'h6: msgData = idw2_ff[15:8];
            3'h7: msgData = idw2_ff[7:0];
            default: msgData = temp_ff;
        endcase
        msgCrc = crcStep(`TNL_CRC_SEED, msgId_ff);
        msgCrc = crcStep(msgCrc, msgData[7:4]);
        msgCrc = crcTab(crcStep(msgCrc, msgData[3:0]));
    end

    // Frame checksum over status, angle and, by counter mode and slow channel, frame count and bus address
    always @* begin
        crcRun = crcStep(`TNL_CRC_SEED, statusNow);
        crcRun = crcStep(crcRun, angle_ff[11:8]);
        crcRun = crcStep(crcRun, angle_ff[7:4]);
        crcRun = crcStep(crcRun, angle_ff[3:0]);
        if (ctrMode == `TNL_CTR_NIBBLE) begin
            crcRun = crcStep(crcRun, frameCnt_ff);
            if (slowEn) begin
                crcRun = crcStep(crcRun, {2'h0, busAddr});
            end
        end else if (ctrMode == `TNL_CTR_IN_CRC) begin
            crcRun = crcStep(crcRun, {frameCnt_ff[1:0],
                                      slowEn ? busAddr : 2'h0});
        end else if (slowEn) begin
            crcRun = crcStep(crcRun, {2'h0, busAddr});
        end
        frameCrc = crcTab(crcRun);
    end

    // Value and length of the nibble in flight
    always @* begin
        case (nibIdx_ff)
            3'h1: nibVal = statusLat_ff;
            3'h2: nibVal = angleLat_ff[11:8];
            3'h3: nibVal = angleLat_ff[7:4];
            3'h4: nibVal = angleLat_ff[3:0];
            3'h5: nibVal = frameCnt_ff;
            3'h6: nibVal = crcLat_ff;
            default: nibVal = 4'h0;
        endcase
        case (nibIdx_ff)
            IDX_SYNC: nibLen = `TNL_SYNC_UT;
            IDX_END: nibLen = `TNL_END_UT;
            default: nibLen = `TNL_NIB_BASE_UT + {3'h0, nibVal};
        endcase
    end

    // Trigger and frame sequencer
    always @* begin
        nxt_state = state_ff;
        nxt_utCnt = utCnt_ff;
        nxt_lowCnt = lowCnt_ff;
        nxt_nibIdx = nibIdx_ff;
        nxt_target = target_ff;
        restart = 1'b0;
        startFrame = 1'b0;
        endFrame = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                if (!lineIn) begin
                    nxt_state = ST_LOW;
                    restart = 1'b1;
                    nxt_utCnt = 7'h00;
                    nxt_lowCnt = 16'h0001;
                end
            end
            ST_LOW: begin
                if (utTick && utCnt_ff != 7'h7F) begin
                    nxt_utCnt = utCnt_ff + 7'h01;
                end
                if (lowCnt_ff != 16'hFFFF) begin
                    nxt_lowCnt = lowCnt_ff + 16'h0001;
                end
                if (lineIn) begin
                    if (!trigHit) begin
                        nxt_state = ST_IDLE;
                    end else if (trigVar) begin
                        nxt_state = ST_WAIT;
                        restart = 1'b1;
                        nxt_utCnt = 7'h00;
                        nxt_target = `TNL_TRIG_VAR_UT;
                    end else begin
                        nxt_state = ST_WAIT;
                        nxt_target = `TNL_TRIG_CONST_UT;
                    end
                end
            end
            ST_WAIT: begin
                if (utTick) begin
                    if (utCnt_ff + 7'h01 >= target_ff) begin
                        startFrame = 1'b1;
                        nxt_state = ST_SEND;
                        nxt_utCnt = 7'h00;
                        nxt_nibIdx = IDX_SYNC;
                    end else begin
                        nxt_utCnt = utCnt_ff + 7'h01;
                    end
                end
            end
            ST_SEND: begin
                if (utTick) begin
                    if (utCnt_ff + 7'h01 == nibLen) begin
                        nxt_utCnt = 7'h00;
                        if (nibIdx_ff == IDX_END) begin
                            endFrame = 1'b1;
                            nxt_state = ST_IDLE;
                        end else if (nibIdx_ff == IDX_DATA3 &&
                                     ctrMode != `TNL_CTR_NIBBLE) begin
                            nxt_nibIdx = IDX_CRC;
                        end else begin
                            nxt_nibIdx = nibIdx_ff + 3'h1;
                        end
                    end else begin
                        nxt_utCnt = utCnt_ff + 7'h01;
                    end
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
        nxt_lineOe = (nxt_state == ST_SEND) && (nxt_utCnt < lowUt);
    end

    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            state_ff <= ST_IDLE;
            utCnt_ff <= 7'h00;
            lowCnt_ff <= 16'h0000;
            nibIdx_ff <= IDX_SYNC;
            target_ff <= 7'h00;
            lineOe_ff <= 1'b0;
            frameDone_ff <= 1'b0;
            statusLat_ff <= 4'h0;
            angleLat_ff <= 12'h000;
            crcLat_ff <= 4'h0;
            frameCnt_ff <= 4'h0;
            rstInd_ff <= 1'b1;
            bitPos_ff <= 4'h0;
            msgId_ff <= 4'h0;
            msgWord_ff <= 16'h0000;
        end else begin
            state_ff <= nxt_state;
            utCnt_ff <= nxt_utCnt;
            lowCnt_ff <= nxt_lowCnt;
            nibIdx_ff <= nxt_nibIdx;
            target_ff <= nxt_target;
            lineOe_ff <= nxt_lineOe;
            frameDone_ff <= endFrame;
            if (startFrame) begin
                statusLat_ff <= statusNow;
                angleLat_ff <= angle_ff;
                crcLat_ff <= frameCrc;
                if (slowEn && bitPos_ff == 4'h0) begin
                    msgWord_ff <= msgNew;
                end
            end
            if (endFrame) begin
                frameCnt_ff <= frameCnt_ff + 4'h1;
                rstInd_ff <= 1'b0;
                if (slowEn) begin
                    bitPos_ff <= bitPos_ff + 4'h1;
                    if (bitPos_ff == 4'hF) begin
                        msgId_ff <= msgId_ff + 4'h1;
                    end
                end
            end
        end
    end

    // Register slave: one wait cycle per access
    assign wrEn = avsWrite && ack_ff;
    assign avsWaitrequest = (avsRead || avsWrite) && !ack_ff;
    assign avsReadData = rdData_ff;
    // Read mux holds the addressed register zero extended, so merge into it
    assign wrWord = wrMerge(rdMux, avsWriteData, avsByteEnable);

    always @* begin
        case (avsAddress)
            `TNL_OFS_CTRL: rdMux = {22'h0, ctrl_ff};
            `TNL_OFS_STATUS: rdMux = {18'h0, rstInd_ff,
                                      state_ff != ST_IDLE, msgId_ff,
                                      bitPos_ff, frameCnt_ff};
            `TNL_OFS_ANGLE: rdMux = {20'h0, angle_ff};
            `TNL_OFS_FAULT: rdMux = {30'h0, fault_ff};
            `TNL_OFS_TEMP: rdMux = {24'h0, temp_ff};
            `TNL_OFS_BASE: rdMux = {16'h0, base_ff};
            `TNL_OFS_IDW1: rdMux = {16'h0, idw1_ff};
            `TNL_OFS_IDW2: rdMux = {16'h0, idw2_ff};
            default: rdMux = 32'h0000_0000;
        endcase
    end

    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            ack_ff <= 1'b0;
            rdData_ff <= 32'h0000_0000;
            ctrl_ff <= `TNL_CTRL_RST;
            angle_ff <= 12'h000;
            fault_ff <= `TNL_FAULT_RST;
            temp_ff <= 8'h00;
            base_ff <= 16'h0000;
            idw1_ff <= 16'h0000;
            idw2_ff <= 16'h0000;
        end else begin
            ack_ff <= (avsRead || avsWrite) && !ack_ff;
            if (avsRead && !ack_ff) begin
                rdData_ff <= rdMux;
            end
            if (wrEn) begin
                case (avsAddress)
                    `TNL_OFS_CTRL: ctrl_ff <= wrWord[9:0];
                    `TNL_OFS_ANGLE: angle_ff <= wrWord[11:0];
                    `TNL_OFS_FAULT: fault_ff <= wrWord[1:0];
                    `TNL_OFS_TEMP: temp_ff <= wrWord[7:0];
                    `TNL_OFS_BASE: base_ff <= wrWord[15:0];
                    `TNL_OFS_IDW1: idw1_ff <= wrWord[15:0];
                    `TNL_OFS_IDW2: idw2_ff <= wrWord[15:0];
                    default: begin
                    end
                endcase
            end
        end
    end
endmodule // tnl_link_tx

// >>> design/tnl_ut_timer.v
// Unit time tick generator
`timescale 1ns/100ps
`include "tnl_consts.vh"

module tnl_ut_timer (
    input wire mclk,
    input wire reset,
    input wire restart,
    input wire [1:0] utSel,
    output wire utTick
);
    reg [9:0] cnt_ff;
    wire [31:0] periodFull;
    wire [9:0] lastCnt;

    assign periodFull = `TNL_UT_MIN_CYC + `TNL_UT_STEP_CYC * {30'h0, utSel};
    assign lastCnt = periodFull[9:0] - 10'h001;
    assign utTick = !restart && (cnt_ff == lastCnt);

    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            cnt_ff <= 10'h000;
        end else if (restart || cnt_ff == lastCnt) begin
            cnt_ff <= 10'h000;
        end else begin
            cnt_ff <= cnt_ff + 10'h001;
        end
    end
endmodule // tnl_ut_timer

// >>> verification/tb_top.sv
// Testbench for the nibble link transmitter
`timescale 1ns/100ps
module tb_top;
    localparam int UT = 375;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic [5:0] avsAddress = 6'h00;
    logic avsRead = 1'b0;
    logic avsWrite = 1'b0;
    logic [31:0] avsWriteData = 32'h00000000;
    logic [3:0] avsByteEnable = 4'hF;
    wire [31:0] avsReadData;
    wire avsWaitrequest;
    wire lineOut;
    wire lineOe;
    wire frameDone;
    wire masterPull;
    wire lineIn = !lineOe && !masterPull;
    int nErrors = 0;
    int totalChecks = 0;
    int nFrames = 0;
    longint cyc = 0;
    longint relT = 0;
    longint rises[$];
    longint widths[$];
    logic oeQ = 1'b0;
    logic mpQ = 1'b0;
    logic [31:0] rd;
    int expUt[6];
    always #2 mclk = ~mclk;
    tnl_link_tx uut (.mclk(mclk), .reset(reset), .avsAddress(avsAddress),
        .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
        .avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
        .avsWaitrequest(avsWaitrequest), .lineIn(lineIn), .lineOut(lineOut),
        .lineOe(lineOe), .frameDone(frameDone));
    tnl_trig_master u_mst (.mclk(mclk), .lineOe(lineOe),
        .masterPull(masterPull));
    // Records falling edges of the line and how long each is held low
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        oeQ <= lineOe;
        mpQ <= masterPull;
        if (lineOe && !oeQ) rises.push_back(cyc);
        if (!lineOe && oeQ) widths.push_back(cyc - rises[$]);
        if (!masterPull && mpQ) relT <= cyc;
        if (frameDone) nFrames <= nFrames + 1;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            nErrors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [5:0] a,
        input logic [31:0] d);
        @(posedge mclk);
        avsAddress <= a;
        avsWriteData <= d;
        avsWrite <= wr;
        avsRead <= !wr;
        @(posedge mclk iff !avsWaitrequest);
        rd = avsReadData;
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
    endtask
    // Shifts status and data in from seed 5, then one zero nibble
    function automatic logic [3:0] crc4(input logic [15:0] msg);
        logic [3:0] c;
        logic [19:0] m;
        logic fb;
        c = 4'h5;
        m = {msg, 4'h0};
        for (int i = 19; i >= 0; i--) begin
            fb = c[3];
            c = {c[2:0], m[i]};
            if (fb) c = c ^ 4'hD;
        end
        return c;
    endfunction
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", totalChecks, nErrors);
        if (nErrors == 0 && totalChecks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        #392000;
        nErrors++;
        tally_and_finish();
    end
    initial begin
        repeat (16) @(posedge mclk);
        reset <= 1'b0;
        bus(1'b0, 6'h00, 32'h0);
        check(rd, 32'h00000000);
        bus(1'b0, 6'h04, 32'h0);
        check(rd & 32'h0000300F, 32'h00002000);
        bus(1'b1, 6'h04, 32'hFFFFFFFF);
        bus(1'b0, 6'h04, 32'h0);
        check(rd & 32'h0000300F, 32'h00002000);
        bus(1'b0, 6'h20, 32'h0);
        check(rd, 32'h00000000);
        bus(1'b1, 6'h10, 32'h00000080);
        bus(1'b0, 6'h10, 32'h0);
        check(rd, 32'h00000080);
        // Variable trigger, 5 UT low time, no counter nibble, address 0
        bus(1'b1, 6'h00, 32'h0000001C);
        bus(1'b0, 6'h00, 32'h0);
        check(rd, 32'h0000001C);
        bus(1'b1, 6'h08, 32'h00000012);
        bus(1'b1, 6'h0C, 32'h00000001);
        u_mst.pull(5 * UT);
        repeat (20 * UT) @(posedge mclk);
        check(rises.size(), 32'h0);
        u_mst.pull(10 * UT);
        wait (nFrames == 1);
        @(posedge mclk);
        check(rises.size(), 32'h7);
        check(rises[0] - relT inside {[12 * UT - 2:13 * UT]}, 32'h1);
        expUt = '{56, 24, 12, 13, 14, 12 + crc4(16'hC012)};
        for (int i = 0; i < 6; i++) begin
            check(rises[i + 1] - rises[i], expUt[i] * UT);
        end
        foreach (widths[i]) check(widths[i], 5 * UT);
        bus(1'b0, 6'h04, 32'h0);
        check(rd & 32'h0000300F, 32'h00000001);
        tally_and_finish();
    end
endmodule // tb_top

// >>> verification/tnl_link_tx_checker.sv
// Port assertions for the nibble link transmitter
`timescale 1ns/100ps
module tnl_link_tx_checker (
    input wire mclk,
    input wire reset,
    input wire [5:0] avsAddress,
    input wire avsRead,
    input wire avsWrite,
    input wire [31:0] avsReadData,
    input wire avsWaitrequest,
    input wire lineIn,
    input wire lineOut,
    input wire lineOe,
    input wire frameDone
);
    logic oeQ_ff;
    logic [15:0] hiCnt_ff;
    logic [15:0] riseGap_ff;
    wire req = avsRead | avsWrite;
    // Cycles the line is pulled, and cycles since the last falling edge
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            oeQ_ff <= 1'b0;
            hiCnt_ff <= 16'h0000;
            riseGap_ff <= 16'hFFFF;
        end else begin
            oeQ_ff <= lineOe;
            hiCnt_ff <= lineOe ? hiCnt_ff + 16'h0001 : 16'h0000;
            if (lineOe && !oeQ_ff)
                riseGap_ff <= 16'h0000;
            else if (riseGap_ff != 16'hFFFF)
                riseGap_ff <= riseGap_ff + 16'h0001;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    chk_wait_one: assert property ($rose(req) |->
        avsWaitrequest ##1 !avsWaitrequest) else $error("bad wait state");
    chk_wait_req: assert property (avsWaitrequest |-> req)
        else $error("wait without request");
    chk_line_out: assert property (!lineOut)
        else $error("line driven high");
    chk_low_width: assert property ($fell(lineOe) |->
        hiCnt_ff % 125 == 0 && hiCnt_ff inside {[1125:3750]})
        else $error("nibble low time off");
    chk_nibble_gap: assert property ($rose(lineOe) |->
        riseGap_ff >= 16'd4499) else $error("nibble too short");
    chk_done_end: assert property (frameDone |-> !lineOe &&
        riseGap_ff inside {[4499:9002]}) else $error("bad frame end");
    chk_rise_idle: assert property ($rose(lineOe) |-> $past(lineIn))
        else $error("frame started while line held low");
    chk_unmapped_zero: assert property (avsRead && !avsWaitrequest &&
        avsAddress == 6'h20 |-> avsReadData == 32'h0)
        else $error("unmapped read not zero");
    cover property (frameDone);
    cover property ($rose(lineOe));
    cover property (avsRead && !avsWaitrequest);
endmodule // tnl_link_tx_checker

bind tnl_link_tx tnl_link_tx_checker u_chk (.mclk(mclk), .reset(reset),
    .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsReadData(avsReadData), .avsWaitrequest(avsWaitrequest),
    .lineIn(lineIn), .lineOut(lineOut), .lineOe(lineOe),
    .frameDone(frameDone));

// >>> verification/tnl_trig_master.sv
// Trigger master model on the shared open-drain line
`timescale 1ns/100ps
module tnl_trig_master (
    input wire mclk,
    input wire lineOe,
    output logic masterPull
);
    initial masterPull = 1'b0;
    // Pulls the line low for a count of cycles once the link is quiet
    task automatic pull(input int cycles);
        wait (!lineOe);
        repeat (4500) @(posedge mclk);
        masterPull <= 1'b1;
        repeat (cycles) @(posedge mclk);
        masterPull <= 1'b0;
    endtask
endmodule // tnl_trig_master
